/* File: core/eeprom_write_pkg.sv */
// constants, state types and transfer carriers of the eeprom write path
// assumes one instance per bus segment with a fixed hardware select value
//
// Notes on behaviour
// RULE1 - master opens every write with start, write-mode device byte, word byte, then data
// RULE2 - writes into a protected region are acknowledged, then aborted; device ready again
// RULE3 - byte location uses 9 address bits (4-Kbit) or 10 (8-Kbit), top ones in device byte
// RULE4 - device acks address and data; master's stop starts the self-timed write
// RULE5 - during the self-timed write all bus traffic is ignored, nothing is acknowledged
// RULE6 - one cycle commits up to 16 bytes of one row; shorter pages are accepted
// RULE7 - page write: up to fifteen more bytes after the first, each acked, stop starts cycle
// RULE8 - only the low four address bits advance per data byte, wrapping within the page
// RULE9 - master should avoid page wrap since earlier bytes of the page get overwritten
// RULE10 - polling with write-mode device byte is nacked while busy, acked once finished
// RULE11 - protection register is read by random read and changed by a checked byte write; here reads are not acknowledged, the register shows on protect_config_o
// RULE12 - protection access uses type 1011b, hardware bits, bit 1 ignored, bit 0 direction
// RULE13 - on the 8-Kbit variant device byte bit 2 is ignored for protection access
// RULE14 - protection access needs word address top bits 11b, other six ignored
// RULE15 - protect enable at bit 3: 0 disables protection and block select has no effect
// RULE16 - block select at bits 2:1: quarter, half, three quarters, whole array protected
// RULE17 - protection write aborts unchanged if data bit 5 differs from lock bit 0
// RULE18 - once locked, the protection register never changes again
// RULE19 - delivered state: enable 0, block select 00, lock 0, nothing protected
// RULE20 - with enable set, each array write is checked against block select
// RULE21 - every protection write must carry data bit 6 set, upper nibble 4h or 6h; data bits 7 and 4 are not checked
// RULE22 - protection register reads return bits 7 to 4 as zero
// RULE23 - protection write with more than one data byte aborts, register unchanged
// RULE24 - protected ranges start at 180h/300h, 100h/200h, 080h/100h, or cover everything
// RULE25 - write cycle length is a clock-cycle parameter; its end clears busy
// RULE26 - a repeated start before stop cancels the write, so random reads can set address

package eeprom_write_pkg;

    // ==============================================================
    // variant and addressing
    localparam logic WIDE_VARIANT = 1'b1;
    localparam logic [3:0] ARRAY_TYPE_ID = 4'hA;
    localparam logic [3:0] PROTECT_TYPE_ID = 4'hB;
    // strap value, arbitrary
    localparam logic [1:0] HW_SELECT = 2'h0;
    localparam logic [1:0] PROTECT_WORD_TAG = 2'h3;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [4:0] COUNT_MAX = 5'h1F;
    localparam logic [5:0] ROWS_PER_QUARTER = WIDE_VARIANT ? 6'h10 : 6'h08;

    // ==============================================================
    // protection register layout
    localparam int PE_BIT = 3;
    localparam int BS_HI_BIT = 2;
    localparam int BS_LO_BIT = 1;
    localparam int LOCK_BIT = 0;
    localparam int CONFIRM_BIT = 5;
    localparam int MARK_BIT = 6;
    localparam logic [3:0] PROTECT_RESET = 4'h0;

    // ==============================================================
    // timing
    // plain default; set per product to the required cycle length
    localparam int WRITE_CYCLES_DEFAULT = 1000;

    // ==============================================================
    // states and carriers
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_RECV = 2'b01,
        LINK_ACK = 2'b10,
        LINK_SKIP = 2'b11
    } link_state_type;

    typedef enum logic [1:0] {
        KIND_DEV = 2'b00,
        KIND_WORD = 2'b01,
        KIND_DATA = 2'b10
    } byte_kind_type;

    typedef enum logic {
        PROG_IDLE = 1'b0,
        PROG_RUN = 1'b1
    } prog_state_type;

    typedef struct packed {
        link_state_type st;
        byte_kind_type kind;
        logic [3:0] bits;
        logic [7:0] shift;
        logic scl_p;
        logic sda_p;
        logic ack_oe;
        logic sda_level;
        logic to_protect;
        logic [9:0] addr;
        logic [15:0][7:0] page;
        logic [15:0] mask;
        logic [4:0] count;
        logic [7:0] first;
        logic req;
    } link_regs_type;

    typedef struct packed {
        prog_state_type st;
        logic [19:0] timer;
        logic ack;
        logic busy;
        logic commit;
        logic [3:0] cfg;
        logic [7:0] cfg_out;
        logic [7:0] peek;
    } prog_regs_type;

endpackage : eeprom_write_pkg

/* File: core/level_sync.sv */
// two-stage synchroniser for levels and toggles entering a clock domain
// assumes inputs change slowly against the receiving clock
`timescale 1ns/1ns

module level_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // signals
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_stages_type;

    sync_stages_type q;
    sync_stages_type d;

    always_comb begin
        d.first = async_i;
        d.second = q.first;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.second;

endmodule : level_sync

/* File: core/eeprom_write_protect.sv */
// write path of a two-wire serial eeprom with software write protection
// assumes link_clk_i runs free and fast enough to oversample scl and sda
`timescale 1ns/1ns

module eeprom_write_protect #(
    parameter int WRITE_CYCLES = eeprom_write_pkg::WRITE_CYCLES_DEFAULT
) (
    // clocks and reset
    input wire logic sys_clk_i,
    input wire logic link_clk_i,
    input wire logic rst_i,
    // two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // status and array view
    output logic busy_o,
    output logic [7:0] protect_config_o,
    input wire logic [9:0] peek_addr_i,
    output logic [7:0] peek_data_o
);
    import eeprom_write_pkg::*;

    // ==============================================================
    // link domain
    link_regs_type lq;
    link_regs_type ld;
    logic [1:0] pins_s;
    logic ack_s;
    logic scl_s;
    logic sda_s;
    logic rise;
    logic fall;
    logic start_seen;
    logic stop_seen;
    logic link_busy;
    logic hw_ok;

    prog_regs_type sq;
    prog_regs_type sd;

    level_sync #(.WIDTH(2)) pin_sync (
        .clk_i(link_clk_i),
        .rst_i(rst_i),
        .async_i({scl_i, sda_i}),
        .sync_o(pins_s)
    );

    level_sync #(.WIDTH(1)) done_sync (
        .clk_i(link_clk_i),
        .rst_i(rst_i),
        .async_i(sq.ack),
        .sync_o(ack_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];
    assign rise = scl_s & ~lq.scl_p;
    assign fall = ~scl_s & lq.scl_p;
    assign start_seen = scl_s & lq.scl_p & lq.sda_p & ~sda_s;
    assign stop_seen = scl_s & lq.scl_p & ~lq.sda_p & sda_s;
    // busy from the moment the request toggles until the done toggle returns
    assign link_busy = lq.req ^ ack_s;
    // 8-Kbit: bit 2 carries the top address bit, so only bit 3 is compared
    assign hw_ok = WIDE_VARIANT ? (lq.shift[3] == HW_SELECT[1]) : (lq.shift[3:2] == HW_SELECT); // RULE13 RULE12

    always_comb begin
        ld = lq;
        ld.scl_p = scl_s;
        ld.sda_p = sda_s;
        ld.sda_level = 1'b0;
        if (start_seen) begin
            // restart drops any pending page without raising a request
            ld.st = LINK_RECV; // RULE26 RULE1
            ld.kind = KIND_DEV;
            ld.bits = '0;
            ld.ack_oe = 1'b0;
        end else if (stop_seen) begin
            if (lq.st == LINK_RECV && lq.kind == KIND_DATA && lq.count != '0) begin
                ld.req = ~lq.req; // RULE4 RULE7 RULE6
            end
            ld.st = LINK_IDLE;
            ld.ack_oe = 1'b0;
        end else begin
            case (lq.st)
                LINK_RECV: begin
                    if (rise && lq.bits != BYTE_BITS) begin
                        ld.shift = {lq.shift[6:0], sda_s};
                        ld.bits = lq.bits + 4'h1;
                    end else if (fall && lq.bits == BYTE_BITS) begin
                        ld.bits = '0;
                        ld.st = LINK_ACK;
                        case (lq.kind)
                            KIND_DEV: begin
                                // reads are outside this block and are not acknowledged
                                ld.ack_oe = (lq.shift[7:4] == ARRAY_TYPE_ID || lq.shift[7:4] == PROTECT_TYPE_ID)
                                    && hw_ok && !lq.shift[0] && !link_busy; // RULE5 RULE10
                                // a refused byte leaves the page alone; a running cycle still reads it
                                if (ld.ack_oe) begin // RULE5
                                    ld.to_protect = (lq.shift[7:4] == PROTECT_TYPE_ID);
                                    ld.addr[9:8] = WIDE_VARIANT ? lq.shift[2:1] : {1'b0, lq.shift[1]}; // RULE3
                                    ld.mask = '0;
                                    ld.count = '0;
                                end
                                ld.kind = KIND_WORD;
                            end
                            KIND_WORD: begin
                                ld.ack_oe = !lq.to_protect || (lq.shift[7:6] == PROTECT_WORD_TAG); // RULE14
                                ld.addr[7:0] = lq.shift;
                                ld.kind = KIND_DATA;
                            end
                            default: begin
                                // data is acknowledged even when it will later be refused
                                ld.ack_oe = 1'b1; // RULE2
                                ld.page[lq.addr[3:0]] = lq.shift;
                                ld.mask[lq.addr[3:0]] = 1'b1;
                                if (lq.count == '0) begin
                                    ld.first = lq.shift;
                                end
                                if (lq.count != COUNT_MAX) begin
                                    ld.count = lq.count + 5'h01;
                                end
                                // wrap inside the row; a second pass overwrites earlier bytes
                                ld.addr[3:0] = lq.addr[3:0] + 4'h1; // RULE8 RULE9
                            end
                        endcase
                    end
                end
                LINK_ACK: begin
                    if (fall) begin
                        ld.ack_oe = 1'b0;
                        ld.st = lq.ack_oe ? LINK_RECV : LINK_SKIP;
                    end
                end
                default: begin
                    ld.st = lq.st;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    assign sda_o = lq.sda_level;
    assign sda_oe_o = lq.ack_oe;

    // ==============================================================
    // system domain: protection check, timed cycle, array
    logic req_s;
    logic pend;
    logic [5:0] row;
    logic [5:0] limit;
    logic array_prot;
    logic cfg_ok;
    logic [7:0] mem_q [0:1023];

    level_sync #(.WIDTH(1)) req_sync (
        .clk_i(sys_clk_i),
        .rst_i(rst_i),
        .async_i(lq.req),
        .sync_o(req_s)
    );

    // page data is held stable by the link until the done toggle returns
    assign pend = req_s ^ sq.ack;
    assign row = lq.addr[9:4];

    always_comb begin
        case ({sq.cfg[BS_HI_BIT], sq.cfg[BS_LO_BIT]})
            2'b00: limit = 6'(ROWS_PER_QUARTER * 6'h03); // RULE16 RULE24
            2'b01: limit = 6'(ROWS_PER_QUARTER * 6'h02);
            2'b10: limit = ROWS_PER_QUARTER;
            default: limit = 6'h00;
        endcase
    end

    assign array_prot = sq.cfg[PE_BIT] && (row >= limit); // RULE15 RULE20
    assign cfg_ok = !sq.cfg[LOCK_BIT] && (lq.count == 5'h01) && lq.first[MARK_BIT]
        && (lq.first[CONFIRM_BIT] == lq.first[LOCK_BIT]); // RULE17 RULE18 RULE21 RULE23

    always_comb begin
        sd = sq;
        sd.commit = 1'b0;
        sd.peek = mem_q[peek_addr_i];
        sd.cfg_out = {4'h0, sq.cfg}; // RULE22 RULE11
        case (sq.st)
            PROG_IDLE: begin
                if (pend) begin
                    if (lq.to_protect ? !cfg_ok : array_prot) begin
                        // refused writes finish at once and leave the device ready
                        sd.ack = ~sq.ack; // RULE2
                    end else begin
                        if (lq.to_protect) begin
                            sd.cfg = lq.first[3:0];
                        end
                        sd.st = PROG_RUN;
                        sd.timer = '0;
                        sd.busy = 1'b1;
                    end
                end
            end
            default: begin
                if (sq.timer == 20'(WRITE_CYCLES - 1)) begin
                    sd.st = PROG_IDLE; // RULE25
                    sd.busy = 1'b0;
                    sd.ack = ~sq.ack;
                    sd.commit = !lq.to_protect;
                end else begin
                    sd.timer = sq.timer + 20'h00001;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sq <= '0;
            sq.cfg <= PROTECT_RESET; // RULE19
        end else begin
            sq <= sd;
        end
    end

    // array itself has no reset; cells keep their content
    always_ff @(posedge sys_clk_i) begin
        if (sq.commit) begin
            for (int i = 0; i < 16; i++) begin
                if (lq.mask[i]) begin
                    mem_q[{row, 4'(i)}] <= lq.page[i]; // RULE6
                end
            end
        end
    end

    assign busy_o = sq.busy;
    assign protect_config_o = sq.cfg_out;
    assign peek_data_o = sq.peek;

    // ==============================================================
    // checks
    int unsigned busy_len_q;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_len_q <= 0;
        end else begin
            busy_len_q <= sq.busy ? busy_len_q + 1 : 0;
        end
    end

    sequence s_new_req;
        (sq.st == PROG_IDLE) && pend;
    endsequence

    sequence s_data_stop;
        stop_seen && (lq.st == LINK_RECV) && (lq.kind == KIND_DATA) && (lq.count != '0);
    endsequence

    a_protected_abort: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE2
        s_new_req ##0 (!lq.to_protect && array_prot) |=> $changed(sq.ack) && !busy_o)
        else $error("protected array write was not aborted at once");
    a_lock_holds: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE18
        sq.cfg[LOCK_BIT] |=> $stable(sq.cfg))
        else $error("locked protection register changed");
    a_confirm_mismatch: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE17
        s_new_req ##0 (lq.to_protect && lq.first[CONFIRM_BIT] != lq.first[LOCK_BIT]) |=> $stable(sq.cfg))
        else $error("mismatched lock confirm changed the register");
    a_multi_byte_cfg: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE23
        s_new_req ##0 (lq.to_protect && lq.count > 5'h01) |=> $stable(sq.cfg) ##1 !busy_o)
        else $error("multi-byte protection write was accepted");
    a_read_upper_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE22
        protect_config_o[7:4] == 4'h0)
        else $error("protection register upper nibble not zero");
    a_cycle_length: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE25
        $fell(busy_o) |-> (busy_len_q == WRITE_CYCLES) && $past(sq.ack) != sq.ack)
        else $error("write cycle length differs from the parameter");
    a_busy_nack: assert property (@(posedge link_clk_i) disable iff (rst_i) // RULE5
        (lq.st == LINK_RECV && lq.kind == KIND_DEV && fall && lq.bits == BYTE_BITS && link_busy)
        |=> !sda_oe_o ##1 !sda_oe_o)
        else $error("device byte acknowledged during write cycle");
    a_stop_commits: assert property (@(posedge link_clk_i) disable iff (rst_i) // RULE4
        s_data_stop |=> $changed(lq.req) && lq.st == LINK_IDLE)
        else $error("stop after data did not start a write cycle");
    a_restart_quiet: assert property (@(posedge link_clk_i) disable iff (rst_i) // RULE26
        start_seen |=> $stable(lq.req) && lq.kind == KIND_DEV)
        else $error("repeated start raised a write request");
    a_row_kept: assert property (@(posedge link_clk_i) disable iff (rst_i) // RULE8
        (lq.kind == KIND_DATA) |=> lq.addr[9:4] == $past(lq.addr[9:4]))
        else $error("row bits moved during a page write");
    a_page_held: assert property (@(posedge link_clk_i) disable iff (rst_i) // RULE5
        link_busy |=> $stable(lq.mask) && $stable(lq.addr) && $stable(lq.to_protect))
        else $error("page changed while the write cycle ran");

endmodule : eeprom_write_protect

/* File: tb/i2c_master_model.sv */
// two-wire bus master issuing write, poll and abandoned sequences
// assumes a pull-up on sda outside; every step lands one clk_i edge later
`timescale 1ns/1ns

module i2c_master_model (
    // clock
    input wire logic clk_i,
    // bus
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // ==========================================
    // pin steps
    logic cur;

    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        cur = 1'b1;
    end

    // outside start_cond and stop_cond, sda only moves while scl is low, so no false start or stop is seen
    task automatic step(input logic scl, input logic sda);
        @(posedge clk_i);
        scl_o <= scl;
        sda_low_o <= ~sda;
        cur = sda;
    endtask : step

    task automatic start_cond();
        step(1'b0, cur);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : start_cond

    task automatic stop_cond();
        step(1'b0, cur);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : stop_cond

    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, cur);
            step(1'b0, b[i]);
            step(1'b1, b[i]);
        end
        step(1'b0, cur);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        @(posedge clk_i);
        ack = ~sda_i;
    endtask : send_byte

    // ==========================================
    // sequences
    task automatic write_seq(input logic [7:0] dev, input logic [7:0] word, input int n,
                             input logic [15:0][7:0] d, input logic stop_end,
                             output logic dev_ack, output logic all_ack);
        logic a;
        start_cond();
        send_byte(dev, dev_ack);
        all_ack = dev_ack;
        if (dev_ack === 1'b1) begin
            send_byte(word, a);
            all_ack = all_ack & a;
            // never more than one page, so no slot is loaded twice
            for (int i = 0; i < n && i < 16; i++) begin
                send_byte(d[i], a);
                all_ack = all_ack & a;
            end
        end
        if (stop_end) begin
            stop_cond();
        end
    endtask : write_seq

    task automatic poll(input logic [7:0] dev, output logic ack);
        start_cond();
        send_byte(dev, ack);
        stop_cond();
    endtask : poll

endmodule : i2c_master_model

/* File: tb/eeprom_write_protect_bench.sv */
// self-checking bench for the eeprom write path and protection register
// assumes the package settings: 8-Kbit variant, hardware select 0
`timescale 1ns/1ns

module eeprom_write_protect_bench;
    import eeprom_write_pkg::*;

    // ==========================================
    // signals
    localparam int WC = 200;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic scl, sda_low, sda_o, sda_oe, busy, a, b;
    logic [7:0] cfg, peek_data;
    logic [9:0] peek_addr = 10'h000;
    logic [15:0][7:0] d;
    logic [9:0] lim [4] = '{10'h300, 10'h200, 10'h100, 10'h000};
    logic [7:0] bad_dev [3] = '{8'hA1, 8'hC0, 8'hA8};
    wire sda = ~(sda_low | (sda_oe & ~sda_o));
    int mismatches = 0;
    int check_count = 0;
    int busy_len = 0;
    int busy_runs = 0;
    int run_len = 0;
    int runs0;

    always #20 sys_clk = ~sys_clk;
    // link rising edges at odd multiples of 3 ns never meet a sys_clk rising edge
    always #3 link_clk = ~link_clk;

    always @(posedge sys_clk) begin
        if (busy === 1'b1) begin
            run_len <= run_len + 1;
        end else if (run_len != 0) begin
            busy_len <= run_len;
            busy_runs <= busy_runs + 1;
            run_len <= 0;
        end
    end

    eeprom_write_protect #(.WRITE_CYCLES(WC)) i_dut (
        .sys_clk_i(sys_clk), .link_clk_i(link_clk), .rst_i(rst),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .busy_o(busy), .protect_config_o(cfg), .peek_addr_i(peek_addr), .peek_data_o(peek_data)
    );

    i2c_master_model i_master (.clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

    // ==========================================
    // tasks
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wait_idle();
        int t;
        repeat (10) @(negedge sys_clk);
        t = 0;
        while (busy === 1'b1 && t < WC + 50) begin
            @(negedge sys_clk);
            t++;
        end
        if (t >= WC + 50) begin
            check(0, 1, "write cycle never ended");
            end_sim();
        end
        repeat (4) @(negedge sys_clk);
    endtask : wait_idle

    task automatic xfer(input logic [7:0] dev, input logic [7:0] word, input int n, input logic run);
        runs0 = busy_runs;
        i_master.write_seq(dev, word, n, d, 1'b1, a, b);
        wait_idle();
        check(busy_runs - runs0, run, "write cycle count");
        if (run) begin
            check(busy_len, WC, "busy length");
        end
    endtask : xfer

    task automatic aw(input logic [9:0] addr, input int n, input logic run);
        xfer({4'hA, 1'b0, addr[9:8], 1'b0}, addr[7:0], n, run);
        check(b, 1'b1, "array write acks");
    endtask : aw

    task automatic cfgw(input logic [7:0] v, input logic run);
        d[0] = v;
        xfer(8'hB0, 8'hC0, 1, run);
    endtask : cfgw

    task automatic peek(input logic [9:0] addr, input logic [7:0] exp);
        @(posedge sys_clk);
        peek_addr <= addr;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check(peek_data, exp, "array byte");
    endtask : peek

    // ==========================================
    // sequence
    initial begin
        d = '0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(negedge sys_clk);
        check(cfg, 8'h00, "config after reset");
        check({busy, sda_oe}, 2'b00, "idle after reset");
        d[0] = 8'h5A;
        aw(10'h3FF, 1, 1'b1);
        peek(10'h3FF, 8'h5A);
        d[0] = 8'h33;
        i_master.write_seq(8'hA0, 8'h01, 1, d, 1'b1, a, b);
        i_master.poll(8'hA0, a);
        check(a, 1'b0, "poll while busy");
        wait_idle();
        i_master.poll(8'hA0, a);
        check(a, 1'b1, "poll after cycle");
        peek(10'h001, 8'h33);
        for (int i = 0; i < 16; i++) d[i] = 8'(8'h20 + i);
        aw(10'h10E, 16, 1'b1);
        for (int i = 0; i < 16; i++) peek({6'h10, 4'(4'hE + i)}, 8'(8'h20 + i));
        runs0 = busy_runs;
        i_master.write_seq(8'hA0, 8'h40, 1, d, 1'b0, a, b);
        i_master.poll(8'hA0, a);
        wait_idle();
        check(busy_runs - runs0, 0, "repeated start cycle");
        for (int i = 0; i < 3; i++) begin
            i_master.poll(bad_dev[i], a);
            check(a, 1'b0, "refused device byte");
        end
        d[0] = 8'h4A;
        xfer(8'hB0, 8'h80, 1, 1'b0);
        check(b, 1'b0, "bad word for config");
        cfgw(8'h0A, 1'b0);
        cfgw(8'h6A, 1'b0);
        d[1] = 8'h4A;
        xfer(8'hB0, 8'hC0, 2, 1'b0);
        check(cfg, 8'h00, "config after refusals");
        d[0] = 8'h46;
        xfer(8'hB6, 8'hDF, 1, 1'b1);
        check(cfg, 8'h06, "config enable off");
        d[0] = 8'h99;
        aw(10'h3FE, 1, 1'b1);
        for (int s = 0; s < 4; s++) begin
            cfgw({4'h4, 1'b1, 2'(s), 1'b0}, 1'b1);
            check(cfg, {4'h0, 1'b1, 2'(s), 1'b0}, "config level");
            d[0] = 8'hC3;
            aw(10'h3FF, 1, 1'b0);
            peek(10'h3FF, 8'h5A);
            d[0] = 8'(s);
            if (s < 3) aw(lim[s] - 10'h001, 1, 1'b1);
            aw(lim[s], 1, 1'b0);
        end
        cfgw(8'h61, 1'b1);
        check(cfg, 8'h01, "config locked");
        cfgw(8'h4E, 1'b0);
        check(cfg, 8'h01, "config stays locked");
        end_sim();
    end

endmodule : eeprom_write_protect_bench
